/* File: shared/sysctl_pkg.sv */
// constants, types and register map of the system controller register bank
package sysctl_pkg;

  localparam int ADDR_W = 8;

  // processor core map
  localparam logic [7:0] OFF_PORT_A_DIR   = 8'h00;
  localparam logic [7:0] OFF_PORT_B_DIR   = 8'h01;
  localparam logic [7:0] OFF_PORT_A_DATA  = 8'h02;
  localparam logic [7:0] OFF_PORT_B_DATA  = 8'h03;
  localparam logic [7:0] OFF_TIMER_CS     = 8'h08;
  localparam logic [7:0] OFF_FRC_HI       = 8'h09;
  localparam logic [7:0] OFF_FRC_LO       = 8'h0a;
  localparam logic [7:0] OFF_CMP_HI       = 8'h0b;
  localparam logic [7:0] OFF_CMP_LO       = 8'h0c;
  localparam logic [7:0] OFF_CAP_HI       = 8'h0d;
  localparam logic [7:0] OFF_CAP_LO       = 8'h0e;
  localparam logic [7:0] OFF_SER_RATE     = 8'h10;
  localparam logic [7:0] OFF_SER_CS       = 8'h11;
  localparam logic [7:0] OFF_SER_RX       = 8'h12;
  localparam logic [7:0] OFF_SER_TX       = 8'h13;
  localparam logic [7:0] OFF_RAM_CTRL     = 8'h14;
  // peripheral map
  localparam logic [7:0] OFF_EXT_IN       = 8'h22;
  localparam logic [7:0] OFF_EXT_OUT      = 8'h24;
  localparam logic [7:0] OFF_INT_STAT     = 8'h2c;
  localparam logic [7:0] OFF_EXT_STAT     = 8'h2e;
  localparam logic [7:0] OFF_MODEM_A      = 8'h30;
  localparam logic [7:0] OFF_MODEM_B      = 8'h32;
  localparam logic [7:0] OFF_MODEM_C      = 8'h34;
  localparam logic [7:0] OFF_KEYPAD       = 8'h36;
  localparam logic [7:0] OFF_CIF_RX_A     = 8'h3a;
  localparam logic [7:0] OFF_CIF_RX_B     = 8'h3c;
  localparam logic [7:0] OFF_CIF_RX_C     = 8'h3e;
  localparam logic [7:0] OFF_PORT_D       = 8'h40;
  localparam logic [7:0] OFF_PORT_E       = 8'h42;
  localparam logic [7:0] OFF_BANK_SEL     = 8'h44;
  localparam logic [7:0] OFF_BAUD_SEL     = 8'h53;
  localparam logic [7:0] OFF_TW_ADDR      = 8'h54;
  localparam logic [7:0] OFF_TW_DATA      = 8'h55;
  localparam logic [7:0] OFF_TW_CTRL      = 8'h56;
  localparam logic [7:0] OFF_TW_STAT      = 8'h57;
  localparam logic [7:0] OFF_PWM_ONE      = 8'h5b;
  localparam logic [7:0] OFF_PWM_TWO      = 8'h5c;
  localparam logic [7:0] OFF_CIF_TX_A     = 8'h60;
  localparam logic [7:0] OFF_CIF_TX_B     = 8'h62;
  localparam logic [7:0] OFF_CIF_TX_C     = 8'h64;
  localparam logic [7:0] OFF_CIF_CTRL     = 8'h66;
  localparam logic [7:0] OFF_STROBE_W     = 8'h67;
  localparam logic [7:0] OFF_WD_RESTART   = 8'h6a;
  localparam logic [7:0] OFF_TO_RESTART   = 8'h6c;
  localparam logic [7:0] OFF_INT_CLR      = 8'h70;
  localparam logic [7:0] OFF_INT_MASK     = 8'h72;
  localparam logic [7:0] OFF_EXT_CLR      = 8'h74;
  localparam logic [7:0] OFF_EXT_MASK     = 8'h76;

  // reset values
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_CMP          = 8'hff;
  localparam logic [7:0] RST_SER_RATE     = 8'h00;
  localparam logic [7:0] RST_SER_RATE_SV  = 8'h0c;
  localparam logic [7:0] RST_SER_CS       = 8'h20;
  localparam logic [7:0] RST_SER_CS_SV    = 8'h3a;
  localparam logic [7:0] RST_PORT_D       = 8'h02;
  localparam logic [7:0] RST_PORT_E       = 8'h03;
  localparam logic [7:0] RST_TW_STAT      = 8'hf8;
  localparam logic [7:0] BAUD_9600        = 8'h04;

  // field positions
  localparam int EXT_IN_SERVICE_MODE_PIN_BIT = 6;
  localparam int PWR_OFF_BIT     = 4;
  localparam int INT_UNUSED_BIT  = 4;
  localparam int EXT_IRQ_W       = 4;
  localparam int KEY_IN_W        = 4;
  localparam logic [3:0] CHIP_ID_DEFAULT = 4'h5; // arbitrary value

  // timeouts in the service-free normal mode
  localparam int CLK_HZ      = 20_000_000;
  localparam int WD_TIME_S   = 4;
  localparam int TO_TIME_S   = 30;
  localparam longint WD_CYCLES = longint'(WD_TIME_S) * CLK_HZ;
  localparam longint TO_CYCLES = longint'(TO_TIME_S) * CLK_HZ;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [7:0] pa_dir;
    logic [7:0] pb_dir;
    logic [7:0] pa_out;
    logic [7:0] pb_out;
    logic [7:0] timer_cs;
    logic [7:0] cmp_hi;
    logic [7:0] cmp_lo;
    logic [7:0] ser_rate;
    logic [7:0] ser_cs;
    logic [7:0] ser_tx;
    logic [7:0] ext_out;
    logic [7:0] modem_a;
    logic [7:0] modem_b;
    logic [7:0] modem_c;
    logic [7:0] port_d;
    logic [7:0] port_e;
    logic [7:0] bank_sel;
    logic [7:0] baud_sel;
    logic [7:0] tw_addr;
    logic [7:0] tw_data;
    logic [7:0] tw_ctrl;
    logic [7:0] tw_ccr;
    logic [7:0] pwm_one;
    logic [7:0] pwm_two;
    logic [7:0] cif_tx_a;
    logic [7:0] cif_tx_b;
    logic [7:0] cif_tx_c;
    logic [7:0] cif_ctrl;
    logic [7:0] strobe_w;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
    logic [3:0] ext_stat;
    logic [3:0] ext_mask;
    logic [31:0] wd_cnt;
    logic [31:0] to_cnt;
    logic        wd_rst;
    logic        to_rst;
    logic        init;
    logic [31:0] prdata;
  } regs_s;

endpackage

/* File: rtl/sysctl_regs.sv */
// system controller register bank behind an APB slave
// Functional notes
// - input port bit 6 shows service pin
// - input port bits 1:0 invert external status
// - power-off bit resets 1 in service
// - chip interface receive regs follow data flag
// - direction registers reset to inputs
// - core fixed in multiplexed bus mode
// - serial rate resets 0x0c in service
// - serial status resets 0x20 or 0x3a
// - ram control location reads zero, read-only
// - internal clear write clears chosen flags
// - external clear write clears low flags
// - keypad register holds keys and id
// - undefined reset bits read live inputs
// - serial status register read and write
// - service mode inhibits timeout resets
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs #(
  parameter longint   WD_CYCLES = sysctl_pkg::WD_CYCLES,
  parameter longint   TO_CYCLES = sysctl_pkg::TO_CYCLES,
  parameter logic [3:0] CHIP_ID = sysctl_pkg::CHIP_ID_DEFAULT
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // pins
  input  wire logic        SERVICE_MODE_PIN,
  input  wire logic [7:0]  PORT_A_IN,
  input  wire logic [7:0]  PORT_B_IN,
  input  wire logic [7:0]  EXT_IN,
  input  wire logic [3:0]  KEY_IN,
  input  wire logic [23:0] RX_DATA_FLAG_INPUT,
  // events
  input  wire logic [7:0]  INT_EVENT,
  input  wire logic [3:0]  EXT_EVENT,
  // outputs
  output logic [7:0]       PORT_A_OUT,
  output logic [7:0]       PORT_A_OE,
  output logic [7:0]       PORT_B_OUT,
  output logic [7:0]       PORT_B_OE,
  output logic [7:0]       EXT_OUT,
  output logic             POWER_OFF_CONTROL_BIT,
  output logic             MUX_BUS_MODE,
  output logic             IRQ,
  output logic             WATCHDOG_RESET,
  output logic             TIMEOUT_RESET
);

  if (WD_CYCLES < 2 || WD_CYCLES > 64'hffffffff || TO_CYCLES < 2 || TO_CYCLES > 64'hffffffff)
  begin
    $error("timeout counts out of range");
  end

  sysctl_pkg::regs_s q, d;
  logic [1:0]  service_mode_pin_sync;
  logic [7:0]  pa_s1, pa_s2, pb_s1, pb_s2, ext_s1, ext_s2;
  logic [3:0]  key_s1, key_s2;
  logic [23:0] rx_s1, rx_s2;
  logic        service_mode_pin;
  logic        wr, rd;
  logic [7:0]  a;

  // service pin sync runs through reset so the strap sees the pin at release
  always_ff @(posedge CLK)
  begin
    service_mode_pin_sync <= {service_mode_pin_sync[0], SERVICE_MODE_PIN};
  end

  // pin synchronisers
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pa_s1 <= 8'h00; pa_s2 <= 8'h00; pb_s1 <= 8'h00; pb_s2 <= 8'h00;
      ext_s1 <= 8'h00; ext_s2 <= 8'h00; key_s1 <= 4'h0; key_s2 <= 4'h0;
      rx_s1 <= 24'h000000; rx_s2 <= 24'h000000;
    end
    else
    begin
      pa_s1 <= PORT_A_IN; pa_s2 <= pa_s1; pb_s1 <= PORT_B_IN; pb_s2 <= pb_s1;
      ext_s1 <= EXT_IN; ext_s2 <= ext_s1; key_s1 <= KEY_IN; key_s2 <= key_s1;
      rx_s1 <= RX_DATA_FLAG_INPUT; rx_s2 <= rx_s1;
    end
  end
  assign service_mode_pin = service_mode_pin_sync[1];

  // pair decode: core map exact, peripheral pairs drop bit 0
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off, input logic pair);
    hit = pair ? (adr[7:1] == off[7:1]) : (adr == off);
  endfunction

  assign a  = PADDR;
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;

  always_comb
  begin
    logic [7:0] w;
    logic [7:0] r;
    w = PWDATA[7:0];
    r = 8'h00;
    d = q;
    d.wd_rst = 1'b0;
    d.to_rst = 1'b0;
    // post-reset strap capture
    if (q.init)
    begin
      d.init = 1'b0;
      d.port_d[sysctl_pkg::PWR_OFF_BIT] = service_mode_pin;
      d.ser_rate = service_mode_pin ? sysctl_pkg::RST_SER_RATE_SV : sysctl_pkg::RST_SER_RATE;
      d.ser_cs = service_mode_pin ? sysctl_pkg::RST_SER_CS_SV : sysctl_pkg::RST_SER_CS;
    end
    // sticky events, set wins over clear
    d.int_stat = q.int_stat | INT_EVENT;
    d.ext_stat = q.ext_stat | EXT_EVENT;
    if (wr)
    begin
      if (hit(a, sysctl_pkg::OFF_PORT_A_DIR, 1'b0)) d.pa_dir = w;
      if (hit(a, sysctl_pkg::OFF_PORT_B_DIR, 1'b0)) d.pb_dir = w;
      if (hit(a, sysctl_pkg::OFF_PORT_A_DATA, 1'b0)) d.pa_out = w;
      if (hit(a, sysctl_pkg::OFF_PORT_B_DATA, 1'b0)) d.pb_out = w;
      if (hit(a, sysctl_pkg::OFF_TIMER_CS, 1'b0)) d.timer_cs = w;
      if (hit(a, sysctl_pkg::OFF_CMP_HI, 1'b0)) d.cmp_hi = w;
      if (hit(a, sysctl_pkg::OFF_CMP_LO, 1'b0)) d.cmp_lo = w;
      if (hit(a, sysctl_pkg::OFF_SER_RATE, 1'b0)) d.ser_rate = w;
      if (hit(a, sysctl_pkg::OFF_SER_CS, 1'b0)) d.ser_cs = w;
      if (hit(a, sysctl_pkg::OFF_SER_TX, 1'b0)) d.ser_tx = w;
      if (hit(a, sysctl_pkg::OFF_EXT_OUT, 1'b1)) d.ext_out = w;
      if (hit(a, sysctl_pkg::OFF_MODEM_A, 1'b1)) d.modem_a = w;
      if (hit(a, sysctl_pkg::OFF_MODEM_B, 1'b1)) d.modem_b = w;
      if (hit(a, sysctl_pkg::OFF_MODEM_C, 1'b1)) d.modem_c = w;
      if (hit(a, sysctl_pkg::OFF_PORT_D, 1'b1)) d.port_d = w;
      if (hit(a, sysctl_pkg::OFF_PORT_E, 1'b1)) d.port_e = w;
      if (hit(a, sysctl_pkg::OFF_BANK_SEL, 1'b0)) d.bank_sel = w;
      if (hit(a, sysctl_pkg::OFF_BAUD_SEL, 1'b0)) d.baud_sel = w;
      if (hit(a, sysctl_pkg::OFF_TW_ADDR, 1'b0)) d.tw_addr = w;
      if (hit(a, sysctl_pkg::OFF_TW_DATA, 1'b0)) d.tw_data = w;
      if (hit(a, sysctl_pkg::OFF_TW_CTRL, 1'b0)) d.tw_ctrl = w;
      if (hit(a, sysctl_pkg::OFF_TW_STAT, 1'b0)) d.tw_ccr = w;
      if (hit(a, sysctl_pkg::OFF_PWM_ONE, 1'b0)) d.pwm_one = w;
      if (hit(a, sysctl_pkg::OFF_PWM_TWO, 1'b0)) d.pwm_two = w;
      if (hit(a, sysctl_pkg::OFF_CIF_TX_A, 1'b1)) d.cif_tx_a = w;
      if (hit(a, sysctl_pkg::OFF_CIF_TX_B, 1'b1)) d.cif_tx_b = w;
      if (hit(a, sysctl_pkg::OFF_CIF_TX_C, 1'b1)) d.cif_tx_c = w;
      if (hit(a, sysctl_pkg::OFF_CIF_CTRL, 1'b0)) d.cif_ctrl = w;
      if (hit(a, sysctl_pkg::OFF_STROBE_W, 1'b0)) d.strobe_w = w;
      if (hit(a, sysctl_pkg::OFF_WD_RESTART, 1'b1)) d.wd_rst = 1'b1;
      if (hit(a, sysctl_pkg::OFF_TO_RESTART, 1'b1)) d.to_rst = 1'b1;
      if (hit(a, sysctl_pkg::OFF_INT_CLR, 1'b1)) d.int_stat = (q.int_stat & ~w) | INT_EVENT;
      if (hit(a, sysctl_pkg::OFF_INT_MASK, 1'b1)) d.int_mask = w;
      if (hit(a, sysctl_pkg::OFF_EXT_CLR, 1'b1))
        d.ext_stat = (q.ext_stat & ~w[3:0]) | EXT_EVENT;
      if (hit(a, sysctl_pkg::OFF_EXT_MASK, 1'b1)) d.ext_mask = w[3:0];
    end
    // timers; service mode holds them off
    if (service_mode_pin || q.wd_rst) d.wd_cnt = 32'h00000000;
    else if (q.wd_cnt != 32'(WD_CYCLES - 1)) d.wd_cnt = q.wd_cnt + 32'h00000001;
    if (service_mode_pin || q.to_rst) d.to_cnt = 32'h00000000;
    else if (q.to_cnt != 32'(TO_CYCLES - 1)) d.to_cnt = q.to_cnt + 32'h00000001;
    // read mux, captured in setup cycle
    if (hit(a, sysctl_pkg::OFF_PORT_A_DATA, 1'b0)) r = (q.pa_out & q.pa_dir) | (pa_s2 & ~q.pa_dir);
    if (hit(a, sysctl_pkg::OFF_PORT_B_DATA, 1'b0)) r = (q.pb_out & q.pb_dir) | (pb_s2 & ~q.pb_dir);
    if (hit(a, sysctl_pkg::OFF_TIMER_CS, 1'b0)) r = q.timer_cs;
    if (hit(a, sysctl_pkg::OFF_CMP_HI, 1'b0)) r = q.cmp_hi;
    if (hit(a, sysctl_pkg::OFF_CMP_LO, 1'b0)) r = q.cmp_lo;
    if (hit(a, sysctl_pkg::OFF_SER_CS, 1'b0)) r = q.ser_cs;
    if (hit(a, sysctl_pkg::OFF_RAM_CTRL, 1'b0)) r = 8'h00;
    if (hit(a, sysctl_pkg::OFF_EXT_IN, 1'b1))
    begin
      r = ext_s2;
      r[sysctl_pkg::EXT_IN_SERVICE_MODE_PIN_BIT] = service_mode_pin;
      r[1:0] = ~q.ext_stat[1:0];
    end
    if (hit(a, sysctl_pkg::OFF_EXT_OUT, 1'b1)) r = q.ext_out;
    if (hit(a, sysctl_pkg::OFF_INT_STAT, 1'b1)) r = q.int_stat;
    if (hit(a, sysctl_pkg::OFF_EXT_STAT, 1'b1)) r = {4'h0, q.ext_stat};
    if (hit(a, sysctl_pkg::OFF_MODEM_A, 1'b1)) r = q.modem_a;
    if (hit(a, sysctl_pkg::OFF_MODEM_B, 1'b1)) r = q.modem_b;
    if (hit(a, sysctl_pkg::OFF_MODEM_C, 1'b1)) r = q.modem_c;
    if (hit(a, sysctl_pkg::OFF_KEYPAD, 1'b1)) r = {CHIP_ID, key_s2};
    if (hit(a, sysctl_pkg::OFF_CIF_RX_A, 1'b1)) r = rx_s2[7:0];
    if (hit(a, sysctl_pkg::OFF_CIF_RX_B, 1'b1)) r = rx_s2[15:8];
    if (hit(a, sysctl_pkg::OFF_CIF_RX_C, 1'b1)) r = rx_s2[23:16];
    if (hit(a, sysctl_pkg::OFF_PORT_D, 1'b1)) r = q.port_d;
    if (hit(a, sysctl_pkg::OFF_PORT_E, 1'b1)) r = q.port_e;
    if (hit(a, sysctl_pkg::OFF_TW_ADDR, 1'b0)) r = q.tw_addr;
    if (hit(a, sysctl_pkg::OFF_TW_DATA, 1'b0)) r = q.tw_data;
    if (hit(a, sysctl_pkg::OFF_TW_CTRL, 1'b0)) r = q.tw_ctrl;
    if (hit(a, sysctl_pkg::OFF_TW_STAT, 1'b0)) r = sysctl_pkg::RST_TW_STAT;
    if (rd) d.prdata = {24'h000000, r};
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      q <= '0;
      q.cmp_hi <= sysctl_pkg::RST_CMP;
      q.cmp_lo <= sysctl_pkg::RST_CMP;
      q.ser_cs <= sysctl_pkg::RST_SER_CS;
      q.port_d <= sysctl_pkg::RST_PORT_D;
      q.port_e <= sysctl_pkg::RST_PORT_E;
      q.init <= 1'b1;
    end
    else
      q <= d;
  end

  // outputs
  assign PREADY                = 1'b1;
  assign PSLVERR               = 1'b0;
  assign PRDATA                = q.prdata;
  assign PORT_A_OUT            = q.pa_out;
  assign PORT_A_OE             = q.pa_dir;
  assign PORT_B_OUT            = q.pb_out;
  assign PORT_B_OE             = q.pb_dir;
  assign EXT_OUT               = q.ext_out;
  assign POWER_OFF_CONTROL_BIT = q.port_d[sysctl_pkg::PWR_OFF_BIT];
  assign MUX_BUS_MODE          = 1'b1;
  assign IRQ                   = |(q.int_stat & q.int_mask) || |(q.ext_stat & q.ext_mask);
  assign WATCHDOG_RESET        = !service_mode_pin && (q.wd_cnt == 32'(WD_CYCLES - 1));
  assign TIMEOUT_RESET         = !service_mode_pin && (q.to_cnt == 32'(TO_CYCLES - 1));

  // checks
  sequence s_clr_write;
    wr && hit(a, sysctl_pkg::OFF_INT_CLR, 1'b1);
  endsequence

  a_dir_reset: assert property (@(posedge CLK) $fell(SYS_RST) |-> PORT_A_OE == 8'h00 && PORT_B_OE == 8'h00)
    else $error("direction not input after reset");
  a_pwr_strap: assert property (@(posedge CLK) disable iff (SYS_RST) q.init |=> POWER_OFF_CONTROL_BIT == $past(service_mode_pin))
    else $error("power-off strap wrong");
  a_rate_strap: assert property (@(posedge CLK) disable iff (SYS_RST)
    q.init |=> q.ser_rate == ($past(service_mode_pin) ? 8'h0c : 8'h00))
    else $error("serial rate strap wrong");
  a_cs_strap: assert property (@(posedge CLK) disable iff (SYS_RST)
    q.init |=> q.ser_cs == ($past(service_mode_pin) ? 8'h3a : 8'h20))
    else $error("serial status strap wrong");
  a_int_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_clr_write |=> (q.int_stat & $past(PWDATA[7:0]) & ~$past(INT_EVENT)) == 8'h00)
    else $error("internal clear failed");
  a_ext_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr && hit(a, sysctl_pkg::OFF_EXT_CLR, 1'b1) |=> (q.ext_stat & $past(PWDATA[3:0]) & ~$past(EXT_EVENT)) == 4'h0)
    else $error("external clear failed");
  a_service_mode_pin_in: assert property (@(posedge CLK) disable iff (SYS_RST)
    rd && hit(a, sysctl_pkg::OFF_EXT_IN, 1'b1) |=> PRDATA[6] == $past(service_mode_pin) && PRDATA[1:0] == ~$past(q.ext_stat[1:0]))
    else $error("input port bits wrong");
  a_ram_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
    rd && hit(a, sysctl_pkg::OFF_RAM_CTRL, 1'b0) |=> PRDATA == 32'h00000000)
    else $error("ram control nonzero");
  a_wd_inhibit: assert property (@(posedge CLK) disable iff (SYS_RST)
    service_mode_pin |-> (!WATCHDOG_RESET && !TIMEOUT_RESET) ##1 (q.wd_cnt == 32'h00000000 && q.to_cnt == 32'h00000000))
    else $error("reset in service mode");
  a_wd_restart: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr && hit(a, sysctl_pkg::OFF_WD_RESTART, 1'b1) |=> ##1 q.wd_cnt == 32'h00000000)
    else $error("watchdog not restarted");
  a_pair_alias: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr && PADDR == 8'h31 |=> q.modem_a == $past(PWDATA[7:0]))
    else $error("odd pair address ignored");
  a_mux_mode: assert property (@(posedge CLK) disable iff (SYS_RST) MUX_BUS_MODE)
    else $error("bus mode not multiplexed");

endmodule
`default_nettype wire

/* File: test/sysctl_regs_tb.sv */
// self-checking testbench of the system controller register bank
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs_tb;
  logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, SERVICE_MODE_PIN;
  logic [7:0]  PADDR, PORT_A_IN, PORT_B_IN, EXT_IN, INT_EVENT;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0]  KEY_IN, EXT_EVENT;
  logic [23:0] RX_DATA_FLAG_INPUT;
  logic [7:0]  PORT_A_OUT, PORT_A_OE, PORT_B_OUT, PORT_B_OE, EXT_OUT;
  logic        PREADY, PSLVERR, POWER_OFF_CONTROL_BIT, MUX_BUS_MODE, IRQ, WATCHDOG_RESET, TIMEOUT_RESET;
  logic [31:0] r;
  int          error_cnt;
  int          comparisons;
  int          cyc;

  sysctl_regs #(.WD_CYCLES(20), .TO_CYCLES(40), .CHIP_ID(4'ha)) u_sysctl_regs (
    .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SERVICE_MODE_PIN(SERVICE_MODE_PIN), .PORT_A_IN(PORT_A_IN), .PORT_B_IN(PORT_B_IN), .EXT_IN(EXT_IN),
    .KEY_IN(KEY_IN), .RX_DATA_FLAG_INPUT(RX_DATA_FLAG_INPUT), .INT_EVENT(INT_EVENT), .EXT_EVENT(EXT_EVENT),
    .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE(PORT_A_OE), .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE(PORT_B_OE),
    .EXT_OUT(EXT_OUT), .POWER_OFF_CONTROL_BIT(POWER_OFF_CONTROL_BIT), .MUX_BUS_MODE(MUX_BUS_MODE),
    .IRQ(IRQ), .WATCHDOG_RESET(WATCHDOG_RESET), .TIMEOUT_RESET(TIMEOUT_RESET)
  );

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    q = PRDATA;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk(nm, q, {24'h000000, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic do_reset;
    @(posedge CLK);
    SYS_RST <= 1'b1;
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  task automatic pulse(input logic [7:0] ie, input logic [3:0] ee);
    @(posedge CLK);
    INT_EVENT <= ie;
    EXT_EVENT <= ee;
    @(posedge CLK);
    INT_EVENT <= 8'h00;
    EXT_EVENT <= 4'h0;
  endtask

  initial
  begin
    {SYS_RST, PSEL, PENABLE, PWRITE, SERVICE_MODE_PIN} = 5'b10000;
    {PADDR, PWDATA, cyc, error_cnt, comparisons} = '0;
    {PORT_A_IN, PORT_B_IN, INT_EVENT, EXT_EVENT} = '0;
    EXT_IN = 8'h3c;
    PORT_B_IN = 8'h96;
    KEY_IN = 4'h9;
    RX_DATA_FLAG_INPUT = 24'hc35aa5;
    do_reset();
    // normal mode reset state
    @(negedge CLK);
    chk("port_a_oe", {24'h0, PORT_A_OE}, 32'h0);
    chk("port_b_oe", {24'h0, PORT_B_OE}, 32'h0);
    chk("mux_mode", {31'h0, MUX_BUS_MODE}, 32'h1);
    chk("pwr_off", {31'h0, POWER_OFF_CONTROL_BIT}, 32'h0);
    rdc("ser_cs", sysctl_pkg::OFF_SER_CS, sysctl_pkg::RST_SER_CS);
    wr(sysctl_pkg::OFF_SER_CS, 8'h5e);
    rdc("ser_cs_wr", sysctl_pkg::OFF_SER_CS, 8'h5e);
    rdc("port_d", sysctl_pkg::OFF_PORT_D, sysctl_pkg::RST_PORT_D);
    rdc("port_e", sysctl_pkg::OFF_PORT_E, sysctl_pkg::RST_PORT_E);
    rdc("cmp_hi", sysctl_pkg::OFF_CMP_HI, sysctl_pkg::RST_CMP);
    rdc("ram_ctrl", sysctl_pkg::OFF_RAM_CTRL, 8'h00);
    wr(sysctl_pkg::OFF_RAM_CTRL, 8'hff);
    rdc("ram_ctrl_wr", sysctl_pkg::OFF_RAM_CTRL, 8'h00);
    rdc("unmapped", 8'h45, 8'h00);
    wr(sysctl_pkg::OFF_PORT_A_DIR, 8'ha5);
    wr(sysctl_pkg::OFF_PORT_A_DATA, 8'h5a);
    settle(1);
    chk("port_a_oe_wr", {24'h0, PORT_A_OE}, 32'ha5);
    chk("port_a_out", {24'h0, PORT_A_OUT}, 32'h5a);
    wr(sysctl_pkg::OFF_PORT_B_DIR, 8'h0f);
    wr(sysctl_pkg::OFF_PORT_B_DATA, 8'h3c);
    wr(8'h25, 8'h81);
    wr(8'h31, 8'h6c);
    settle(1);
    chk("port_b_oe_wr", {24'h0, PORT_B_OE}, 32'h0f);
    chk("port_b_out", {24'h0, PORT_B_OUT}, 32'h3c);
    chk("ext_out", {24'h0, EXT_OUT}, 32'h81);
    chk("slverr", {31'h0, PSLVERR}, 32'h0);
    rdc("port_b_rd", sysctl_pkg::OFF_PORT_B_DATA, 8'h9c);
    rdc("modem_alias", sysctl_pkg::OFF_MODEM_A, 8'h6c);
    rdc("ext_in", sysctl_pkg::OFF_EXT_IN, 8'h3f);
    rdc("keypad", sysctl_pkg::OFF_KEYPAD, 8'ha9);
    rdc("keypad_alias", 8'h37, 8'ha9);
    for (int i = 0; i < 3; i++)
      rdc("cif_rx", sysctl_pkg::OFF_CIF_RX_A + 8'(2 * i), RX_DATA_FLAG_INPUT[8*i +: 8]);
    rdc("cif_rx_alias", 8'h3d, RX_DATA_FLAG_INPUT[15:8]);
    // internal interrupts, bit 4 left out of every compare
    pulse(8'h21, 4'h2);
    xfer(1'b0, sysctl_pkg::OFF_INT_STAT, 8'h00, r);
    chk("int_stat", r & 32'hef, 32'h21);
    settle(0);
    chk("irq_masked", {31'h0, IRQ}, 32'h0);
    wr(sysctl_pkg::OFF_INT_MASK, 8'h01);
    settle(1);
    chk("irq_on", {31'h0, IRQ}, 32'h1);
    wr(sysctl_pkg::OFF_INT_CLR, 8'h01);
    settle(1);
    chk("irq_cleared", {31'h0, IRQ}, 32'h0);
    xfer(1'b0, sysctl_pkg::OFF_INT_STAT, 8'h00, r);
    chk("int_stat_clr", r & 32'hef, 32'h20);
    wr(8'h71, 8'h20);
    xfer(1'b0, sysctl_pkg::OFF_INT_STAT, 8'h00, r);
    chk("int_stat_alias", r & 32'hef, 32'h00);
    // external interrupts
    xfer(1'b0, sysctl_pkg::OFF_EXT_STAT, 8'h00, r);
    chk("ext_stat", r & 32'h0f, 32'h02);
    rdc("ext_in_irq", sysctl_pkg::OFF_EXT_IN, 8'h3d);
    wr(sysctl_pkg::OFF_EXT_MASK, 8'h02);
    settle(1);
    chk("ext_irq_on", {31'h0, IRQ}, 32'h1);
    wr(sysctl_pkg::OFF_EXT_CLR, 8'h02);
    settle(1);
    chk("ext_irq_off", {31'h0, IRQ}, 32'h0);
    xfer(1'b0, sysctl_pkg::OFF_EXT_STAT, 8'h00, r);
    chk("ext_stat_clr", r & 32'h0f, 32'h00);
    // watchdog and time-out restarts
    wr(sysctl_pkg::OFF_TO_RESTART, 8'h00);
    wr(sysctl_pkg::OFF_WD_RESTART, 8'h77);
    settle(3);
    chk("wd_restart", {31'h0, WATCHDOG_RESET}, 32'h0);
    chk("to_restart", {31'h0, TIMEOUT_RESET}, 32'h0);
    settle(45);
    chk("wd_expire", {31'h0, WATCHDOG_RESET}, 32'h1);
    chk("to_expire", {31'h0, TIMEOUT_RESET}, 32'h1);
    wr(8'h6b, 8'hc4);
    settle(3);
    chk("wd_alias", {31'h0, WATCHDOG_RESET}, 32'h0);
    // service mode
    @(posedge CLK);
    SERVICE_MODE_PIN <= 1'b1;
    do_reset();
    @(negedge CLK);
    chk("pwr_off_sv", {31'h0, POWER_OFF_CONTROL_BIT}, 32'h1);
    rdc("ser_cs_sv", sysctl_pkg::OFF_SER_CS, sysctl_pkg::RST_SER_CS_SV);
    rdc("port_d_sv", sysctl_pkg::OFF_PORT_D, 8'h12);
    rdc("ext_in_sv", sysctl_pkg::OFF_EXT_IN, 8'h7f);
    wr(sysctl_pkg::OFF_BAUD_SEL, sysctl_pkg::BAUD_9600);
    settle(45);
    chk("wd_sv", {31'h0, WATCHDOG_RESET}, 32'h0);
    chk("to_sv", {31'h0, TIMEOUT_RESET}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
